// ===== flash_erase_protect_control.v
// Flash program/erase sequencer with protection, interrupt lockout and power states
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "flash_ctrl_defines.vh"

module flash_erase_protect_control (
    input  wire        i_sys_clk,
    input  wire        i_reset,
    // AXI4-Lite slave
    input  wire [3:0]  i_awaddr,
    input  wire        i_awvalid,
    output wire        o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output wire        o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [3:0]  i_araddr,
    input  wire        i_arvalid,
    output wire        o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // Chip state
    input  wire        i_write_enable_pin,
    input  wire [2:0]  i_power_state,
    input  wire        i_boot_running,
    input  wire        i_ram_overlay_enable,
    // CPU activity on flash
    input  wire        i_flash_read,
    input  wire        i_exception,
    input  wire        i_sleep_exec,
    input  wire        i_dma_grant,
    input  wire        i_flash_write,
    input  wire        i_flash_addr_lsb,
    input  wire [7:0]  i_flash_wdata,
    input  wire [15:0] i_array_rdata,
    // Flash array side
    output reg  [2:0]  o_array_mode,
    output reg  [15:0] o_array_block_sel,
    output reg         o_verify_armed,
    output reg  [15:0] o_flash_rdata,
    output reg         o_flash_powered,
    output reg         o_flash_read_only,
    output reg         o_irq_mask,
    output reg         o_error_flag
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg  [7:0]  flash_ctrl_reg_one;
    reg  [7:0]  erase_block_sel_one;
    reg  [7:0]  erase_block_sel_two;
    reg         aw_held;
    reg         w_held;
    reg  [3:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [2:0]  next_mode;
    // Control register two is built on read and holds no state of its own
    reg  [7:0]  ctrl_two_view;
    reg  [31:0] read_word;
    reg         we_sync_a;
    reg         we_sync_b;
    reg         we_sync_c;
    reg         we_level;

    wire        hw_protect;
    wire        low_power;
    wire        executing;
    wire        busy_mode;
    wire        verify_mode;
    wire        error_event;
    wire        do_write;
    wire        aw_mapped;
    wire        ar_mapped;
    wire [15:0] block_sel;

    // Standby, watch and module stop count as hardware protection
    assign hw_protect = (i_power_state == `PWR_STANDBY) ||
                        (i_power_state == `PWR_WATCH) ||
                        (i_power_state == `PWR_MODSTOP);

    // Subclock states keep the array readable but never writable
    assign low_power = (i_power_state == `PWR_SUBACTIVE) ||
                       (i_power_state == `PWR_SUBSLEEP);

    assign block_sel = {erase_block_sel_two, erase_block_sel_one};

    assign executing = flash_ctrl_reg_one[`BIT_PROG_EXEC] |
                       flash_ctrl_reg_one[`BIT_ERASE_EXEC];

    assign busy_mode   = (o_array_mode == `MODE_PROGRAM) || (o_array_mode == `MODE_ERASE);
    assign verify_mode = (o_array_mode == `MODE_PVERIFY) || (o_array_mode == `MODE_EVERIFY);

    // Any illegal CPU activity during program or erase
    assign error_event = busy_mode &&
                         (i_flash_read ||
                          i_exception ||
                          i_sleep_exec ||
                          i_dma_grant);

    // ------------------------------------------------------------------
    // Write-enable pin synchroniser
    // ------------------------------------------------------------------
    // The pin is asynchronous; a level counts only once the two late stages
    // agree, so a glitch shorter than a clock never opens the array.
    // Resets to the protected level at the cost of a few cycles of latency.
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            we_sync_a <= 1'b0;
            we_sync_b <= 1'b0;
            we_sync_c <= 1'b0;
            we_level  <= 1'b0;
        end else begin
            we_sync_a <= i_write_enable_pin;
            we_sync_b <= we_sync_a;
            we_sync_c <= we_sync_b;
            if (we_sync_b == we_sync_c) begin
                we_level <= we_sync_c;
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    // A write answers one cycle after both halves are held; one at a time
    assign o_awready = ~aw_held & ~o_bvalid;
    assign o_wready  = ~w_held & ~o_bvalid;
    assign do_write  = aw_held & w_held & ~o_bvalid;

    // Only aligned words inside the map answer OKAY; anything else is refused
    assign aw_mapped = (aw_addr[1:0] == 2'b00) && (aw_addr <= `OFS_BLK_TWO);
    assign ar_mapped = (i_araddr[1:0] == 2'b00) && (i_araddr <= `OFS_BLK_TWO);

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 4'h0;
            w_data   <= 32'h0000_0000;
            w_strb   <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp  <= `RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held <= 1'b1;
                w_data <= i_wdata;
                w_strb <= i_wstrb;
            end
            if (do_write) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= aw_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control and block select registers
    // ------------------------------------------------------------------
    // Only the low byte lane carries register data; other lanes ignored
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            flash_ctrl_reg_one  <= `RESET_BYTE;
            erase_block_sel_one <= `RESET_BYTE;
            erase_block_sel_two <= `RESET_BYTE;
        end else if (hw_protect) begin
            flash_ctrl_reg_one  <= `RESET_BYTE;
            erase_block_sel_one <= `RESET_BYTE;
            erase_block_sel_two <= `RESET_BYTE;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                `OFS_CTRL_ONE: flash_ctrl_reg_one  <= w_data[7:0] & `CTRL_ONE_MASK;
                `OFS_BLK_ONE:  erase_block_sel_one <= w_data[7:0];
                `OFS_BLK_TWO:  erase_block_sel_two <= w_data[7:0];
                default:       flash_ctrl_reg_one  <= flash_ctrl_reg_one;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Error flag
    // ------------------------------------------------------------------
    // Sticky until reset or a halt state (standby, watch, module stop) clears the control registers
    // Reset and the halt states win over a same-cycle event: the array is
    // being shut down, so the flag would be wiped at once anyway
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_error_flag <= 1'b0;
        end else if (hw_protect) begin
            o_error_flag <= 1'b0;
        end else if (error_event) begin
            o_error_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Array mode selection
    // ------------------------------------------------------------------
    // Verify outranks execute so software can still verify under error;
    // subclock states are read only, so they refuse every array mode
    always @* begin
        next_mode = `MODE_IDLE;
        if (hw_protect || low_power || !we_level ||
            !flash_ctrl_reg_one[`BIT_SW_ENABLE]) begin
            next_mode = `MODE_IDLE;
        end else if (flash_ctrl_reg_one[`BIT_PROG_VERIFY]) begin
            next_mode = `MODE_PVERIFY;
        end else if (flash_ctrl_reg_one[`BIT_ERASE_VERIFY]) begin
            next_mode = `MODE_EVERIFY;
        end else if (o_error_flag || error_event || i_ram_overlay_enable) begin
            next_mode = `MODE_IDLE;
        end else if (flash_ctrl_reg_one[`BIT_PROG_EXEC]) begin
            next_mode = `MODE_PROGRAM;
        end else if (flash_ctrl_reg_one[`BIT_ERASE_EXEC] &&
                     block_sel != `BLOCK_ALL_CLEAR) begin
            next_mode = `MODE_ERASE;
        end
    end

    // Erase goes straight from idle; no pre-write step is tracked
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_array_mode      <= `MODE_IDLE;
            o_array_block_sel <= `BLOCK_ALL_CLEAR;
        end else begin
            o_array_mode      <= next_mode;
            o_array_block_sel <= (next_mode == `MODE_ERASE) ?
                                 block_sel : `BLOCK_ALL_CLEAR;
        end
    end

    // ------------------------------------------------------------------
    // Verify dummy write and data path
    // ------------------------------------------------------------------
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_verify_armed <= 1'b0;
            o_flash_rdata  <= 16'h0000;
        end else begin
            // A dummy write outside a verify mode is ignored; leaving verify disarms
            if (!verify_mode) begin
                o_verify_armed <= 1'b0;
            end else if (i_flash_write && !i_flash_addr_lsb &&
                         i_flash_wdata == `VERIFY_BYTE) begin
                o_verify_armed <= 1'b1;
            end
            // Undefined during execution: all ones rather than stored data
            if (executing) begin
                o_flash_rdata <= 16'hffff;
            end else begin
                o_flash_rdata <= i_array_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt lockout and power state
    // ------------------------------------------------------------------
    // Mask follows the execute bits, not the mode, so a refused start still masks
    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_irq_mask        <= 1'b0;
            o_flash_powered   <= 1'b0;
            o_flash_read_only <= 1'b0;
        end else begin
            o_irq_mask        <= executing | i_boot_running;
            o_flash_powered   <= ~hw_protect;
            o_flash_read_only <= low_power;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    // One read in flight; the address is decoded in the cycle it is taken
    assign o_arready = ~o_rvalid;

    always @* begin
        ctrl_two_view = `RESET_BYTE;
        ctrl_two_view[`BIT_ERROR_FLAG] = o_error_flag;
        ctrl_two_view[`BIT_MODE_LO +: 3] = o_array_mode;
        case (i_araddr)
            `OFS_CTRL_ONE: read_word = {24'h000000, flash_ctrl_reg_one};
            `OFS_CTRL_TWO: read_word = {24'h000000, ctrl_two_view};
            `OFS_BLK_ONE:  read_word = {24'h000000, erase_block_sel_one};
            `OFS_BLK_TWO:  read_word = {24'h000000, erase_block_sel_two};
            default:       read_word = 32'h0000_0000;
        endcase
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= `RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata  <= read_word;
            o_rresp  <= ar_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule

// ===== flash_ctrl_defines.vh
// Register offsets, field positions and mode codes of the flash sequencer
`ifndef FLASH_CTRL_DEFINES_VH
`define FLASH_CTRL_DEFINES_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFS_CTRL_ONE     4'h0
`define OFS_CTRL_TWO     4'h4
`define OFS_BLK_ONE      4'h8
`define OFS_BLK_TWO      4'hc

// ------------------------------------------------------------------
// Control register one fields
// ------------------------------------------------------------------
`define BIT_PROG_EXEC    0
`define BIT_ERASE_EXEC   1
`define BIT_PROG_VERIFY  2
`define BIT_ERASE_VERIFY 3
`define BIT_SW_ENABLE    6
`define CTRL_ONE_MASK    8'h4f

// ------------------------------------------------------------------
// Control register two fields
// ------------------------------------------------------------------
`define BIT_ERROR_FLAG   7
`define BIT_MODE_LO      0

// ------------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------------
`define RESET_BYTE       8'h00
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`define VERIFY_BYTE      8'hff
`define BLOCK_ALL_CLEAR  16'h0000

// ------------------------------------------------------------------
// Flash array modes
// ------------------------------------------------------------------
`define MODE_IDLE        3'h0
`define MODE_PROGRAM     3'h1
`define MODE_ERASE       3'h2
`define MODE_PVERIFY     3'h3
`define MODE_EVERIFY     3'h4

// ------------------------------------------------------------------
// Chip power states
// ------------------------------------------------------------------
`define PWR_ACTIVE       3'h0
`define PWR_SLEEP        3'h1
`define PWR_WATCH        3'h2
`define PWR_STANDBY      3'h3
`define PWR_MODSTOP      3'h4
`define PWR_SUBACTIVE    3'h5
`define PWR_SUBSLEEP     3'h6

`endif

// ===== flash_erase_protect_control_chk.sv
// Assertions on the flash sequencer's protection, lockout and power outputs
`timescale 1ns/1ps
`include "flash_ctrl_defines.vh"
module flash_erase_protect_control_chk (
    input wire        i_sys_clk, i_reset, i_ram_overlay_enable, i_flash_read,
    input wire        i_exception, i_sleep_exec, i_dma_grant, o_flash_powered,
    input wire        o_flash_read_only, o_irq_mask, o_error_flag,
    input wire [2:0]  i_power_state, o_array_mode,
    input wire [15:0] o_array_block_sel, o_flash_rdata
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    wire busy = o_array_mode == `MODE_PROGRAM || o_array_mode == `MODE_ERASE;
    wire halted = i_power_state == `PWR_WATCH || i_power_state == `PWR_STANDBY
                  || i_power_state == `PWR_MODSTOP;
    sequence s_busy; busy; endsequence
    sequence s_abort; o_error_flag && o_array_mode == `MODE_IDLE; endsequence
    property p_read_err; s_busy ##0 i_flash_read |=> s_abort; endproperty
    property p_exc_err; s_busy ##0 i_exception |=> s_abort; endproperty
    property p_sleep_err; s_busy ##0 i_sleep_exec |=> s_abort; endproperty
    property p_dma_err; s_busy ##0 i_dma_grant |=> s_abort; endproperty
    property p_err_abort; o_error_flag |-> !busy; endproperty
    property p_err_sticky; o_error_flag && !halted |=> o_error_flag; endproperty
    property p_halt; halted |=> !o_error_flag && !o_flash_powered; endproperty
    property p_mask; s_busy |-> o_irq_mask; endproperty
    // Two busy cycles so the execute bit has surely reached the read path
    property p_undef; s_busy [*2] |-> o_flash_rdata == 16'hffff; endproperty
    property p_blk; o_array_mode == `MODE_ERASE |-> o_array_block_sel != 16'h0000; endproperty
    property p_ovl; i_ram_overlay_enable [*2] |-> !busy; endproperty
    property p_sub; i_power_state == `PWR_SUBACTIVE || i_power_state == `PWR_SUBSLEEP
        |=> o_flash_read_only && !busy; endproperty
    a_read_err: assert property (p_read_err)
        else $error("Flash read while busy not flagged");
    a_exc_err: assert property (p_exc_err)
        else $error("Exception while busy not flagged");
    a_sleep_err: assert property (p_sleep_err)
        else $error("Sleep while busy not flagged");
    a_dma_err: assert property (p_dma_err)
        else $error("Bus grant while busy not flagged");
    a_err_abort: assert property (p_err_abort)
        else $error("Program or erase active under error");
    a_err_sticky: assert property (p_err_sticky)
        else $error("Error flag dropped without protection");
    a_halt: assert property (p_halt)
        else $error("Halt state did not clear error or power");
    a_mask: assert property (p_mask)
        else $error("Interrupts not masked while busy");
    a_undef: assert property (p_undef)
        else $error("Flash read data not undefined while busy");
    a_blk: assert property (p_blk)
        else $error("Erase with no block selected");
    a_ovl: assert property (p_ovl)
        else $error("Program or erase under RAM overlay");
    a_sub: assert property (p_sub)
        else $error("Low-power state not read only");
endmodule

// ===== cpu_bus_model.sv
// Software-side AXI4-Lite master that reaches the flash control registers
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic        clk,
    input  wire logic        awready, wready, bvalid, arready, rvalid,
    input  wire logic [1:0]  bresp,
    output logic      [3:0]  awaddr, araddr, wstrb,
    output logic      [31:0] wdata,
    output logic             awvalid, wvalid, bready, arvalid, rready
);
    logic hung = 1'b0;
    initial begin
        {awaddr, araddr, wstrb, wdata} = 44'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    end
    // Only the low byte lane carries a register
    task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] resp);
        resp = 2'bxx;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        hung = 1'b1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rready <= 1'b0;
                return;
            end
        end
        hung = 1'b1;
    endtask
endmodule

// ===== flash_erase_protect_control_test.sv
// Self-checking testbench of the flash erase and protection sequencer
`timescale 1ns/1ps
`include "flash_ctrl_defines.vh"
module flash_erase_protect_control_test;
    logic        clk = 1'b0, rst = 1'b1, we_pin = 1'b1, boot = 1'b0, ovl = 1'b0;
    logic        fwr = 1'b0, flsb = 1'b0;
    logic [7:0]  fwd = 8'h00, blk;
    logic [2:0]  pwr = `PWR_ACTIVE, mode;
    logic [3:0]  ev = 4'h0, awaddr, araddr, wstrb;
    logic [15:0] ardata = 16'h0000, rnd, blk_sel, frdata;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic        rvalid, rready, armed, powered, ronly, irq_mask, err_flag;
    logic [33:0] exp_q[$];
    int          errors = 0, check_count = 0;
    flash_erase_protect_control u_dut (.i_sys_clk(clk), .i_reset(rst),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_write_enable_pin(we_pin), .i_power_state(pwr),
        .i_boot_running(boot), .i_ram_overlay_enable(ovl), .i_flash_read(ev[0]),
        .i_exception(ev[1]), .i_sleep_exec(ev[2]), .i_dma_grant(ev[3]),
        .i_flash_write(fwr), .i_flash_addr_lsb(flsb), .i_flash_wdata(fwd),
        .i_array_rdata(ardata), .o_array_mode(mode), .o_array_block_sel(blk_sel),
        .o_verify_armed(armed), .o_flash_rdata(frdata), .o_flash_powered(powered),
        .o_flash_read_only(ronly), .o_irq_mask(irq_mask), .o_error_flag(err_flag));
    cpu_bus_model u_cpu (.clk(clk), .awready(awready), .wready(wready), .bvalid(bvalid),
        .arready(arready), .rvalid(rvalid), .bresp(bresp), .awaddr(awaddr),
        .araddr(araddr), .wstrb(wstrb), .wdata(wdata), .awvalid(awvalid),
        .wvalid(wvalid), .bready(bready), .arvalid(arvalid), .rready(rready));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic w(input logic [3:0] a, input logic [7:0] d);
        u_cpu.wr(a, d, r);
    endtask
    // Expected read result is queued before the request goes out
    task automatic rd(input logic [3:0] a, input logic [31:0] d);
        exp_q.push_back({`RESP_OKAY, d});
        u_cpu.rd(a);
    endtask
    task automatic fw(input logic lsb);
        @(posedge clk);
        fwr <= 1'b1;
        flsb <= lsb;
        fwd <= `VERIFY_BYTE;
        @(posedge clk);
        fwr <= 1'b0;
        cyc(2);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
    initial begin
        fork
            wait (u_cpu.hung);
            cyc(20000);
        join_any
        errors++;
        conclude();
    end
    initial begin
        rnd = 16'($urandom(9));
        cyc(10);
        rst <= 1'b0;
        rd(`OFS_CTRL_ONE, 32'h0);
        rd(`OFS_CTRL_TWO, 32'h0);
        rd(`OFS_BLK_ONE, 32'h0);
        rd(`OFS_BLK_TWO, 32'h0);
        u_cpu.wr(4'h1, 8'h40, r);
        chk(r, `RESP_SLVERR);
        $display("Done: reset values and bus errors");
        blk = 8'h01 << ($urandom % 8);
        w(`OFS_BLK_ONE, blk);
        w(`OFS_CTRL_ONE, 8'h42);
        cyc(2);
        chk(mode, `MODE_ERASE);
        chk(blk_sel, {8'h00, blk});
        chk(irq_mask, 1'b1);
        chk(frdata, 16'hffff);
        rd(`OFS_CTRL_TWO, `MODE_ERASE);
        w(`OFS_CTRL_ONE, 8'h40);
        cyc(2);
        chk(mode, `MODE_IDLE);
        w(`OFS_CTRL_ONE, 8'h48);
        fw(1'b1);
        chk(armed, 1'b0);
        fw(1'b0);
        chk(armed, 1'b1);
        rnd = 16'($urandom);
        ardata <= rnd;
        cyc(3);
        chk(frdata, rnd);
        $display("Done: erase and erase-verify");
        for (int k = 0; k < 5; k++) begin
            ovl <= (k == 2);
            we_pin <= (k != 3);
            pwr <= (k == 4) ? `PWR_SUBACTIVE : `PWR_ACTIVE;
            w(`OFS_BLK_ONE, (k == 1) ? 8'h00 : blk);
            w(`OFS_CTRL_ONE, (k == 0) ? 8'h02 : 8'h42);
            cyc(2);
            chk(mode, `MODE_IDLE);
            w(`OFS_CTRL_ONE, 8'h00);
        end
        ovl <= 1'b0;
        we_pin <= 1'b1;
        pwr <= `PWR_ACTIVE;
        $display("Done: software, block and overlay protection");
        for (int e = 0; e < 4; e++) begin
            w(`OFS_BLK_ONE, blk);
            w(`OFS_CTRL_ONE, e[0] ? 8'h41 : 8'h42);
            cyc(2);
            chk(mode, e[0] ? `MODE_PROGRAM : `MODE_ERASE);
            ev <= 4'h1 << e;
            cyc(1);
            ev <= 4'h0;
            cyc(2);
            chk(err_flag, 1'b1);
            rd(`OFS_CTRL_ONE, e[0] ? 32'h41 : 32'h42);
            rd(`OFS_CTRL_TWO, 32'h80);
            w(`OFS_CTRL_ONE, e[0] ? 8'h41 : 8'h42);
            cyc(2);
            chk(mode, `MODE_IDLE);
            w(`OFS_CTRL_ONE, e[0] ? 8'h44 : 8'h48);
            cyc(2);
            chk(mode, e[0] ? `MODE_PVERIFY : `MODE_EVERIFY);
            pwr <= `PWR_STANDBY;
            cyc(1);
            pwr <= `PWR_ACTIVE;
            cyc(2);
            chk(err_flag, 1'b0);
            rd(`OFS_BLK_ONE, 32'h0);
        end
        $display("Done: error protection");
        for (int s = 0; s < 7; s++) begin
            pwr <= s[2:0];
            cyc(3);
            chk(powered, !(s >= 2 && s <= 4));
            chk(ronly, s >= 5);
        end
        pwr <= `PWR_ACTIVE;
        boot <= 1'b1;
        cyc(2);
        chk(irq_mask, 1'b1);
        boot <= 1'b0;
        cyc(2);
        chk(irq_mask, 1'b0);
        $display("Done: power states and boot lockout");
        w(`OFS_BLK_ONE, blk);
        w(`OFS_CTRL_ONE, 8'h42);
        cyc(2);
        rst <= 1'b1;
        cyc(2);
        chk(mode, `MODE_IDLE);
        rst <= 1'b0;
        rd(`OFS_CTRL_ONE, 32'h0);
        cyc(2);
        $display("Done: reset during erase");
        conclude();
    end
endmodule
bind flash_erase_protect_control flash_erase_protect_control_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ram_overlay_enable(i_ram_overlay_enable),
    .i_flash_read(i_flash_read), .i_exception(i_exception), .i_sleep_exec(i_sleep_exec),
    .i_dma_grant(i_dma_grant), .o_flash_powered(o_flash_powered),
    .o_flash_read_only(o_flash_read_only), .o_irq_mask(o_irq_mask),
    .o_error_flag(o_error_flag), .i_power_state(i_power_state), .o_array_mode(o_array_mode),
    .o_array_block_sel(o_array_block_sel), .o_flash_rdata(o_flash_rdata));
